/* File: hw/jesd_link_init_timing.sv */
`timescale 1ns/1ps
// Behaviour
// R1: Sysref source keeps sysref high at least two frame clocks after rising.
// R2: Sysref source keeps sysref low a minimum time before the next rise.
// R3: Multiframe boundary placed a fixed divider-dependent delay after latched sysref.
// R4: That delay in device clock cycles is frame delay times divide ratio.
// R5: First K28.5 frame starts 7 to 9 frames after a boundary.
// R6: First alignment frame starts 7 to 9 frames after a boundary.
// R7: First data frame starts 7 to 9 frames after a boundary.
// R8: Receiver holds sync request low at least four frames to resynchronise.
// R9: Alignment sequence lasts four multiframes, then sample data follows.
// R10: K28.5 sent while sync held; alignment starts at boundary after release.
// R11: Frames per multiframe programmable 9 to 32, 32 after reset.
// R12: Sysref gate disabled after reset; edges ignored until enabled.
// R13: Divide ratio 1, 2, 4 or 8; a change re-initialises the link.
module jesd_link_init_timing
	import jesd_init_pkg::*;
(
	input  wire logic                core_clk_in,
	input  wire logic                rst_in,
	input  wire logic [1:0]          clock_divide_ratio_in,
	input  wire logic                sysref_in,
	input  wire logic                sysref_gate_en_in,
	input  wire logic                link_sync_request_n_in,
	input  wire logic [5:0]          frames_per_mf_in,
	input  wire logic                frames_load_in,
	input  wire logic                sample_valid_in,
	input  wire logic [SAMPLE_W-1:0] sample_data_in,
	output logic                     sample_ready_out,
	output lane_frame_t              lane_frame_out,
	output logic                     lmfc_boundary_out,
	output link_state_t              link_state_out
);
	// ==========================================================
	// Declarations
	// ==========================================================
	logic [1:0]          ratio_r;
	logic [5:0]          frames_r;
	logic                sysref_prev_r;
	logic                sysref_gated;
	logic                sysref_rise;
	logic [7:0]          dly_cnt_r;
	logic                dly_busy_r;
	logic [7:0]          dly_cycles;
	logic [10:0]         dly_scaled;
	logic                align_now;
	logic                aligned_r;
	logic [2:0]          div_cnt_r;
	logic [2:0]          ratio_m1;
	logic                tick;
	logic [5:0]          frame_cnt_r;
	logic [5:0]          cur_frame;
	logic                switch_pt;
	logic                reinit;
	logic [2:0]          sync_low_r;
	logic [2:0]          ila_mf_r;
	logic [2:0]          ila_mf_nxt;
	link_state_t         state_r;
	link_state_t         state_nxt;
	logic                fifo_valid;
	logic [SAMPLE_W-1:0] fifo_data;
	logic                fifo_pop;
	logic [7:0]          sys_age_r;

	// ==========================================================
	// Divider, sysref gate and boundary delay
	// ==========================================================
	// Sysref passes only through the enabled gate; only its rise is used.
	assign sysref_gated = sysref_in && sysref_gate_en_in; // R12
	assign sysref_rise  = sysref_gated && !sysref_prev_r;
	assign reinit       = (clock_divide_ratio_in != ratio_r); // R13
	assign ratio_m1     = 3'((4'h1 << ratio_r) - 4'h1);
	// Fractional frame delay times ratio, rounded up to whole device cycles.
	assign dly_scaled   = ({3'h0, LMFC_DLY_EIGHTHS[ratio_r]} << ratio_r) + 11'h007; // R4
	assign dly_cycles   = dly_scaled[10:3]; // R3
	assign align_now    = dly_busy_r && (dly_cnt_r == 8'h01);
	// A frame clock enable each ratio device cycles, restarted by alignment.
	assign tick         = align_now || (div_cnt_r == 3'h0);
	assign cur_frame    = (align_now || (frame_cnt_r >= frames_r - 6'h01)) ? 6'h00 : frame_cnt_r + 6'h01;
	assign switch_pt    = tick && (cur_frame == TX_LAT_FRAMES); // R5 R6 R7

	// Ratio tracking and the programmable multiframe length.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ratio_r  <= 2'h0;
			frames_r <= FRAMES_RESET;
		end else begin
			ratio_r <= clock_divide_ratio_in;
			if (frames_load_in && frames_per_mf_in >= FRAMES_MIN && frames_per_mf_in <= FRAMES_MAX) begin
				frames_r <= frames_per_mf_in; // R11
			end
		end
	end

	// Latches a gated sysref rise and counts down to the boundary.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sysref_prev_r <= 1'b0;
			dly_cnt_r     <= 8'h00;
			dly_busy_r    <= 1'b0;
			aligned_r     <= 1'b0;
		end else begin
			sysref_prev_r <= sysref_gated;
			if (sysref_rise) begin
				dly_cnt_r  <= dly_cycles; // R3
				dly_busy_r <= 1'b1;
			end else if (dly_busy_r) begin
				dly_cnt_r  <= dly_cnt_r - 8'h01;
				dly_busy_r <= (dly_cnt_r != 8'h01);
			end
			if (reinit) begin
				aligned_r <= 1'b0;
			end else if (align_now) begin
				aligned_r <= 1'b1;
			end
		end
	end

	// Frame divider and frame position within the multiframe.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_cnt_r         <= 3'h0;
			frame_cnt_r       <= 6'h00;
			lmfc_boundary_out <= 1'b0;
		end else begin
			div_cnt_r         <= tick ? ratio_m1 : div_cnt_r - 3'h1;
			lmfc_boundary_out <= tick && (cur_frame == 6'h00);
			if (tick) begin
				frame_cnt_r <= cur_frame;
			end
		end
	end

	// ==========================================================
	// Link sequence
	// ==========================================================
	// Next state; changes take effect only at the fixed frame after a boundary, except a ratio change, which returns to ST_CGS at once.
	always_comb begin
		state_nxt  = state_r;
		ila_mf_nxt = ila_mf_r;
		if (reinit) begin
			state_nxt = ST_CGS; // R13
		end else if (switch_pt) begin
			case (state_r)
				ST_CGS: begin
					if (link_sync_request_n_in && aligned_r) begin
						state_nxt  = ST_ILA; // R10
						ila_mf_nxt = 3'h0;
					end
				end
				ST_ILA: begin
					if (ila_mf_r == ILA_MULTIFRAMES - 3'h1) begin
						state_nxt = ST_DATA; // R9
					end else begin
						ila_mf_nxt = ila_mf_r + 3'h1;
					end
				end
				default: begin
				end
			endcase
			if (state_r != ST_CGS && sync_low_r == SYNC_HOLD_FRAMES && !link_sync_request_n_in) begin
				state_nxt = ST_CGS; // R8
			end
		end
	end

	// Sync hold counter in frames, state and alignment multiframe count.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_low_r     <= 3'h0;
			state_r        <= ST_CGS;
			ila_mf_r       <= 3'h0;
			link_state_out <= ST_CGS;
		end else begin
			if (tick) begin
				if (link_sync_request_n_in) begin
					sync_low_r <= 3'h0;
				end else if (sync_low_r != SYNC_HOLD_FRAMES) begin
					sync_low_r <= sync_low_r + 3'h1;
				end
			end
			state_r        <= state_nxt;
			ila_mf_r       <= ila_mf_nxt;
			link_state_out <= state_nxt;
		end
	end

	// ==========================================================
	// Sample buffer and lane frame output
	// ==========================================================
	assign fifo_pop = tick && (state_nxt == ST_DATA) && fifo_valid;

	sample_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_in   (core_clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (sample_valid_in),
		.in_data_in    (sample_data_in),
		.in_ready_out  (sample_ready_out),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_data),
		.out_ready_in  (fifo_pop)
	);

	// One frame per frame clock: K28.5, alignment frames or sample data.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lane_frame_out <= '0;
		end else begin
			lane_frame_out.valid <= tick;
			if (tick) begin
				case (state_nxt)
					ST_CGS: begin
						lane_frame_out.ctrl   <= 2'h3;
						lane_frame_out.octets <= {K28_5, K28_5}; // R5 R10
					end
					ST_ILA: begin
						if (cur_frame == TX_LAT_FRAMES) begin
							lane_frame_out.ctrl   <= 2'h2;
							lane_frame_out.octets <= {K28_0, 2'h0, cur_frame}; // R6
						end else if (cur_frame == TX_LAT_FRAMES - 6'h01) begin
							lane_frame_out.ctrl   <= 2'h1;
							lane_frame_out.octets <= {2'h0, cur_frame, K28_3};
						end else begin
							lane_frame_out.ctrl   <= 2'h0;
							lane_frame_out.octets <= {2'h0, cur_frame, 2'h0, cur_frame};
						end
					end
					default: begin
						lane_frame_out.ctrl   <= 2'h0;
						lane_frame_out.octets <= fifo_valid ? {fifo_data, 2'h0} : 16'h0000; // R7
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	// Device cycles since the last latched sysref rise.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sys_age_r <= 8'h00;
		end else begin
			sys_age_r <= sysref_rise ? 8'h01 : ((sys_age_r == 8'hFF) ? sys_age_r : sys_age_r + 8'h01);
		end
	end

	gate_closed_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
		!sysref_gate_en_in && !dly_busy_r |=> !dly_busy_r)
		else $error("Sysref passed a closed gate.");
	lmfc_delay_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R3
		align_now && !reinit |-> sys_age_r == dly_cycles ##1 lmfc_boundary_out)
		else $error("Boundary not at the sysref delay.");
	delay_scale_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R4
		sysref_rise && ratio_r == 2'h3 && !reinit |-> dly_cycles == 8'h1D)
		else $error("Delay not scaled by divide ratio.");
	cgs_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R5
		state_r != ST_CGS && state_nxt == ST_CGS && !reinit |-> cur_frame == TX_LAT_FRAMES && tick)
		else $error("K28.5 start off the boundary offset.");
	ila_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R6
		state_r == ST_CGS && state_nxt == ST_ILA |=> lane_frame_out.valid && lane_frame_out.octets[15:8] == K28_0)
		else $error("Alignment start not marked.");
	data_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R7
		state_r == ST_ILA && state_nxt == ST_DATA |-> switch_pt && ila_mf_r == ILA_MULTIFRAMES - 3'h1)
		else $error("Data did not start after four multiframes.");
	sync_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10
		state_r == ST_CGS && !link_sync_request_n_in |=> state_r == ST_CGS)
		else $error("Left K28.5 while sync held.");
	frames_range_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R11
		frames_r >= FRAMES_MIN && frames_r <= FRAMES_MAX)
		else $error("Frames per multiframe out of range.");
	ratio_reinit_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R13
		reinit |=> state_r == ST_CGS && !aligned_r)
		else $error("Ratio change did not re-initialise.");

endmodule : jesd_link_init_timing

/* File: hw/jesd_init_pkg.sv */
package jesd_init_pkg;

	// ==========================================================
	// Clock and sizes
	// ==========================================================
	localparam int unsigned CLK_HZ           = 25_000_000;
	localparam int unsigned SAMPLE_W         = 14;
	localparam int unsigned FIFO_DEPTH       = 16;

	// ==========================================================
	// Multiframe length
	// ==========================================================
	localparam logic [5:0]  FRAMES_RESET     = 6'h20;
	localparam logic [5:0]  FRAMES_MIN       = 6'h09;
	localparam logic [5:0]  FRAMES_MAX       = 6'h20;

	// ==========================================================
	// Timing counts in frames and multiframes
	// ==========================================================
	localparam logic [5:0]  TX_LAT_FRAMES    = 6'h08;
	localparam logic [2:0]  SYNC_HOLD_FRAMES = 3'h4;
	localparam logic [2:0]  SYSREF_HOLD_FRAMES = 3'h2;
	localparam logic [2:0]  ILA_MULTIFRAMES  = 3'h4;

	// Sysref-to-boundary delay in eighths of a frame, per divider code 0..3.
	localparam logic [7:0]  LMFC_DLY_EIGHTHS [0:3] = '{8'h1C, 8'h20, 8'h1E, 8'h1D};

	// ==========================================================
	// Control characters
	// ==========================================================
	localparam logic [7:0]  K28_5            = 8'hBC;
	localparam logic [7:0]  K28_0            = 8'h1C;
	localparam logic [7:0]  K28_3            = 8'h7C;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {ST_CGS, ST_ILA, ST_DATA} link_state_t;

	typedef struct packed {
		logic        valid;
		logic [1:0]  ctrl;
		logic [15:0] octets;
	} lane_frame_t;

endpackage : jesd_init_pkg

/* File: hw/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
	parameter int unsigned WIDTH = 14,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             push;
	logic             pop;

	// Handshakes on both sides; ready and valid come from registers.
	assign push         = in_valid_in && in_ready_out;
	assign pop          = out_valid_out && out_ready_in;
	assign out_data_out = mem[rd_ptr_r];
	assign count_nxt    = count_r + (AW+1)'(push) - (AW+1)'(pop);

	// Storage is written without reset.
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data_in;
		end
	end

	// Pointers, fill level and the registered full and empty flags.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_r      <= '0;
			rd_ptr_r      <= '0;
			count_r       <= '0;
			in_ready_out  <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			wr_ptr_r      <= wr_ptr_r + AW'(push);
			rd_ptr_r      <= rd_ptr_r + AW'(pop);
			count_r       <= count_nxt;
			in_ready_out  <= (count_nxt != (AW+1)'(DEPTH));
			out_valid_out <= (count_nxt != '0);
		end
	end

endmodule : sample_fifo

/* File: dv/rx_partner.sv */
`timescale 1ns/1ps
// ==========================================================
// Receiver and sysref source facing the transmitter
// ==========================================================
module rx_partner (
	input  wire logic       core_clk_in,
	input  wire logic       rst_in,
	input  wire logic [1:0] ratio_in,
	input  wire logic       pulse_in,
	input  wire logic       hold_in,
	input  wire logic       sync_cmd_in,
	input  wire logic [4:0] sync_frames_in,
	output logic            sysref_out,
	output logic            link_sync_request_n_out
);
	int sys_cnt;
	int sync_cnt;
	int rat;

	// Frame length in device clock cycles follows the divide code.
	assign rat = 1 << ratio_in;

	// Sysref is high two frames, then low four frames before it may rise again.
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sys_cnt = 0;
			sync_cnt = 0;
		end else begin
			if (sys_cnt > 0) sys_cnt = sys_cnt - 1;
			else if (pulse_in) sys_cnt = 6 * rat;
			if (sync_cnt > 0) sync_cnt = sync_cnt - 1;
			else if (sync_cmd_in) sync_cnt = sync_frames_in * rat;
		end
		sysref_out <= sys_cnt > 4 * rat;
		link_sync_request_n_out <= !(hold_in || sync_cnt > 0);
	end
endmodule : rx_partner

/* File: dv/jesd_link_init_timing_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the link timing sequencer
// ==========================================================
module jesd_link_init_timing_bench;
	import jesd_init_pkg::*;
	logic                core_clk_in = 1'b0;
	logic                rst_in = 1'b1;
	logic [1:0]          ratio = 2'h0;
	logic                sysref;
	logic                gate_en = 1'b0;
	logic                sync_n;
	logic [5:0]          frames = 6'h00;
	logic                frames_load = 1'b0;
	logic                s_valid = 1'b0;
	logic [SAMPLE_W-1:0] s_data = '0;
	logic                s_ready;
	lane_frame_t         frame;
	logic                bnd;
	link_state_t         state;
	link_state_t         prev_st = ST_CGS;
	logic                pulse = 1'b0;
	logic                hold = 1'b1;
	logic                sync_cmd = 1'b0;
	logic [4:0]          sync_frames = 5'h00;
	logic [SAMPLE_W-1:0] exp_q[$];
	logic [SAMPLE_W-1:0] exp_s;
	logic [31:0]         seed = 32'h0000_a6fb;
	int num_errors = 0, compares = 0, since_bnd = 0, st_cyc = 0, r_now = 1, k_now = 32, n, acc;
	bit skip_phase = 1'b0;

	jesd_link_init_timing dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .clock_divide_ratio_in(ratio),
		.sysref_in(sysref), .sysref_gate_en_in(gate_en), .link_sync_request_n_in(sync_n),
		.frames_per_mf_in(frames), .frames_load_in(frames_load), .sample_valid_in(s_valid),
		.sample_data_in(s_data), .sample_ready_out(s_ready), .lane_frame_out(frame),
		.lmfc_boundary_out(bnd), .link_state_out(state));

	rx_partner partner (.core_clk_in(core_clk_in), .rst_in(rst_in), .ratio_in(ratio), .pulse_in(pulse),
		.hold_in(hold), .sync_cmd_in(sync_cmd), .sync_frames_in(sync_frames), .sysref_out(sysref),
		.link_sync_request_n_out(sync_n));

	// Free-running 25 MHz clock; its start value is set at declaration so no false edge appears at time zero.
	initial begin
		forever #20 core_clk_in = ~core_clk_in;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	task chk(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk

	task finish_test();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test

	task wait_bnd(output int c);
		c = 0;
		do begin
			@(negedge core_clk_in);
			c++;
		end while (bnd !== 1'b1 && c < 3000);
		if (c >= 3000) begin
			chk(1'b0, "boundary timeout");
			finish_test();
		end
	endtask : wait_bnd

	task wait_st(input link_state_t s);
		int c;
		c = 0;
		while (state !== s && c < 3000) begin
			@(negedge core_clk_in);
			c++;
		end
		if (c >= 3000) begin
			chk(1'b0, "state timeout");
			finish_test();
		end
	endtask : wait_st

	task automatic strobe(ref logic sig);
		sig = 1'b1;
		@(negedge core_clk_in);
		sig = 1'b0;
	endtask : strobe

	task load_k(input logic [5:0] k);
		frames = k;
		strobe(frames_load);
		wait_bnd(n);
		wait_bnd(n);
	endtask : load_k

	// Watches frame phase, state timing and frame contents; data notes come off the queue.
	always @(negedge core_clk_in) begin
		since_bnd++;
		st_cyc++;
		if (bnd === 1'b1) begin
			since_bnd = 0;
		end
		if (state !== prev_st) begin
			if (!skip_phase) chk(since_bnd >= 7 * r_now && since_bnd <= 9 * r_now, "frame offset");
			if (state === ST_ILA) chk(frame.ctrl === 2'b10 && frame.octets[15:8] === K28_0, "ila start");
			if (state === ST_DATA) chk(st_cyc == 4 * k_now * r_now, "ila length");
			st_cyc = 0;
			prev_st = state;
		end
		if (frame.valid === 1'b1 && state === ST_CGS) chk(frame === {1'b1, 2'b11, K28_5, K28_5}, "sync frame");
		if (frame.valid === 1'b1 && state === ST_DATA) begin
			exp_s = exp_q.size() > 0 ? exp_q.pop_front() : '0;
			chk(frame === {1'b1, 2'b00, exp_s, 2'b00}, "data frame");
		end
	end

	// Main sequence.
	initial begin
		repeat (16) @(posedge core_clk_in);
		@(negedge core_clk_in);
		chk(frame === '0 && bnd === 1'b0 && state === ST_CGS && s_ready === 1'b0, "reset values");
		rst_in = 1'b0;
		@(negedge core_clk_in);
		chk(s_ready === 1'b1, "ready after reset");
		strobe(pulse);
		// The boundary runs free before alignment; a leaked rise would force one at this cycle.
		repeat ((LMFC_DLY_EIGHTHS[ratio] * r_now + 7) / 8 + 1) @(negedge core_clk_in);
		chk(bnd === 1'b0, "gated sysref");
		repeat (60) @(negedge core_clk_in);
		$display("test sysref gate done");
		gate_en = 1'b1;
		for (int i = 1; i < 5; i++) begin
			ratio = 2'(i);
			r_now = 1 << ratio;
			repeat (60) @(negedge core_clk_in);
			strobe(pulse);
			// A free-running boundary may fall anywhere, so only the aligned cycle is looked at.
			repeat ((LMFC_DLY_EIGHTHS[ratio] * r_now + 7) / 8 + 1) @(negedge core_clk_in);
			chk(bnd === 1'b1, "sysref to boundary");
		end
		$display("test alignment done");
		wait_bnd(n);
		chk(n == 32, "default multiframe");
		load_k(6'h08);
		chk(n == 32, "short multiframe refused");
		load_k(FRAMES_MIN);
		chk(n == 9, "multiframe of nine");
		k_now = 9;
		$display("test multiframe done");
		acc = 0;
		repeat (20) begin
			seed = xs(seed);
			s_data = seed[SAMPLE_W-1:0];
			s_valid = 1'b1;
			if (s_ready === 1'b1) begin
				exp_q.push_back(s_data);
				acc++;
			end
			@(negedge core_clk_in);
		end
		s_valid = 1'b0;
		chk(acc == FIFO_DEPTH && s_ready === 1'b0, "fifo full");
		hold = 1'b0;
		wait_st(ST_DATA);
		repeat (40) @(negedge core_clk_in);
		chk(exp_q.size() == 0, "fifo drained");
		$display("test link start done");
		sync_frames = 5'h02;
		strobe(sync_cmd);
		repeat (40) @(negedge core_clk_in);
		chk(state === ST_DATA, "short sync ignored");
		sync_frames = 5'h10;
		strobe(sync_cmd);
		wait_st(ST_CGS);
		wait_st(ST_DATA);
		$display("test resync done");
		skip_phase = 1'b1;
		ratio = 2'h1;
		repeat (4) @(negedge core_clk_in);
		chk(state === ST_CGS, "ratio change restarts link");
		$display("test ratio change done");
		finish_test();
	end
endmodule : jesd_link_init_timing_bench
